/* hw/mdr_readback.sv */
// Diagnostic readback registers and tach output control of the driver.
`timescale 1ns/1ps
`default_nettype none
module mdr_readback
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Register read port from the serial slave
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_rd_addr,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  // Protection and state flags
  input  wire logic        i_over_temp,
  input  wire logic        i_sleep_state,
  input  wire logic        i_over_curr,
  input  wire logic        i_rotor_locked,
  // Drive state and phase U zero crossings
  input  wire logic        i_spinning,
  input  wire logic        i_open_loop,
  input  wire logic        i_zc_u,
  // Velocity constant integrator result
  input  wire logic        i_kt_valid,
  input  wire logic [15:0] i_kt_value,
  // Inductive position sense result
  input  wire logic        i_ipd_done,
  input  wire logic [2:0]  i_ipd_sector,
  input  wire logic [1:0]  i_ipd_advance,
  // Supply measurement
  input  wire logic        i_supply_valid,
  input  wire logic [7:0]  i_supply_code,
  // Speed sources and output duty
  input  wire logic [1:0]  i_cmd_source,
  input  wire logic [7:0]  i_pwm_duty,
  input  wire logic [7:0]  i_analog_level,
  input  wire logic [8:0]  i_serial_speed,
  input  wire logic [7:0]  i_out_duty,
  // Tach control
  input  wire logic [1:0]  i_open_loop_tach_select,
  input  wire logic        i_tach_toggle,
  output logic             o_tach_out
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  status_q;
  logic [15:0] speed_q;
  logic [15:0] period_q;
  logic [15:0] kt_q;
  logic [7:0]  pos_q;
  logic [7:0]  supply_q;
  logic [7:0]  cmd_q;
  logic [7:0]  duty_q;
  logic [7:0]  speed_snap_q;
  logic [7:0]  period_snap_q;
  logic [7:0]  kt_snap_q;
  logic [7:0]  tick_q;
  logic [15:0] count_q;
  logic        armed_q;
  logic        start_q;
  logic        tach_q;
  logic        tach_d;
  logic        first_done_q;
  logic        open_loop_q;
  logic        rd_valid_q;
  logic [7:0]  rd_data_q;
  logic [7:0]  rd_data_d;
  logic        tick_end;

  mdr_div_if div_bus ();

  mdr_divider u_div
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .div    (div_bus.worker)
  );

  assign div_bus.start   = start_q;
  assign div_bus.divisor = period_q;

  // ****************************************
  // Status flags
  // ****************************************
  // Sampled every cycle so a read sees the present condition.
  // status flag capture
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_q <= mdr_pkg::RST_BYTE;
    end
    else
    begin
      status_q <= mdr_pkg::RST_BYTE;
      status_q[mdr_pkg::ST_OVER_TEMP] <= i_over_temp;
      status_q[mdr_pkg::ST_SLEEP]     <= i_sleep_state;
      status_q[mdr_pkg::ST_OVER_CURR] <= i_over_curr;
      status_q[mdr_pkg::ST_LOCKED]    <= i_rotor_locked;
    end
  end

  // ****************************************
  // Electrical period measurement
  // ****************************************
  assign tick_end = (tick_q == mdr_pkg::TICK_LAST);

  // Period counts whole 10 us ticks between phase U crossings and
  // saturates, so a very slow motor reads as the longest period.
  // period in tick units
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tick_q   <= 8'h00;
      count_q  <= mdr_pkg::RST_WORD;
      armed_q  <= 1'b0;
      period_q <= mdr_pkg::RST_WORD;
      start_q  <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (!i_spinning)
      begin
        armed_q <= 1'b0;
        tick_q  <= 8'h00;
        count_q <= mdr_pkg::RST_WORD;
      end
      else if (i_zc_u)
      begin
        tick_q  <= 8'h00;
        count_q <= mdr_pkg::RST_WORD;
        armed_q <= 1'b1;
        if (armed_q && (count_q != 16'h0000))
        begin
          period_q <= count_q;
          start_q  <= 1'b1;
        end
      end
      else
      begin
        tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
        if (tick_end && (count_q != 16'hFFFF))
        begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // Speed follows each new period once the divider answers; a
  // stopped motor starts no division, so the last speed remains.
  // speed from period
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      speed_q <= mdr_pkg::RST_WORD;
    end
    else if (div_bus.done)
    begin
      speed_q <= div_bus.quot;
    end
  end

  // ****************************************
  // Other measurements
  // ****************************************
  // Each value is taken whenever its source reports a fresh result, the velocity constant only while spinning.
  // velocity constant store
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      kt_q <= mdr_pkg::RST_WORD;
    end
    else if (i_kt_valid && i_spinning)
    begin
      kt_q <= i_kt_value;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pos_q <= mdr_pkg::RST_BYTE;
    end
    else if (i_ipd_done)
    begin
      pos_q <= mdr_pkg::mdr_pos_code(i_ipd_sector, i_ipd_advance);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      supply_q <= mdr_pkg::RST_BYTE;
    end
    else if (i_supply_valid)
    begin
      supply_q <= i_supply_code;
    end
  end

  // The serial command has nine bits; dropping the lowest maps its
  // full scale onto 255 at the cost of one bit of resolution.
  // command source select
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cmd_q  <= mdr_pkg::RST_BYTE;
      duty_q <= mdr_pkg::RST_BYTE;
    end
    else
    begin
      duty_q <= i_out_duty;
      if (i_cmd_source == mdr_pkg::SRC_PWM)
      begin
        cmd_q <= i_pwm_duty;
      end
      else if (i_cmd_source == mdr_pkg::SRC_ANALOG)
      begin
        cmd_q <= i_analog_level;
      end
      else
      begin
        cmd_q <= i_serial_speed[8:1];
      end
    end
  end

  // ****************************************
  // Snapshot bytes for two-byte values
  // ****************************************
  // Reading an upper byte freezes the matching lower byte, so the host
  // gets a consistent word only if it reads upper first.
  // snapshot on upper read
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      speed_snap_q  <= mdr_pkg::RST_BYTE;
      period_snap_q <= mdr_pkg::RST_BYTE;
      kt_snap_q     <= mdr_pkg::RST_BYTE;
    end
    else if (i_rd_en)
    begin
      if (i_rd_addr == mdr_pkg::ADDR_SPEED_HI)
      begin
        speed_snap_q <= speed_q[7:0];
      end
      else if (i_rd_addr == mdr_pkg::ADDR_PER_HI)
      begin
        period_snap_q <= period_q[7:0];
      end
      else if (i_rd_addr == mdr_pkg::ADDR_KT_HI)
      begin
        kt_snap_q <= kt_q[7:0];
      end
    end
  end

  // ****************************************
  // Read decode
  // ****************************************
  // Unmapped offsets read as zero.
  // read-only address block
  always_comb
  begin
    rd_data_d = mdr_pkg::RST_BYTE;
    if (i_rd_addr == mdr_pkg::ADDR_STATUS)
      rd_data_d = status_q;
    else if (i_rd_addr == mdr_pkg::ADDR_SPEED_HI)
      rd_data_d = speed_q[15:8];
    else if (i_rd_addr == mdr_pkg::ADDR_SPEED_LO)
      rd_data_d = speed_snap_q;
    else if (i_rd_addr == mdr_pkg::ADDR_PER_HI)
      rd_data_d = period_q[15:8];
    else if (i_rd_addr == mdr_pkg::ADDR_PER_LO)
      rd_data_d = period_snap_q;
    else if (i_rd_addr == mdr_pkg::ADDR_KT_HI)
      rd_data_d = kt_q[15:8];
    else if (i_rd_addr == mdr_pkg::ADDR_KT_LO)
      rd_data_d = kt_snap_q;
    else if (i_rd_addr == mdr_pkg::ADDR_POS)
      rd_data_d = pos_q;
    else if (i_rd_addr == mdr_pkg::ADDR_SUPPLY)
      rd_data_d = supply_q;
    else if (i_rd_addr == mdr_pkg::ADDR_CMD)
      rd_data_d = cmd_q;
    else if (i_rd_addr == mdr_pkg::ADDR_DUTY)
      rd_data_d = duty_q;
  end

  // Read answer is registered one cycle after the strobe.
  // live upper bytes and snapshot lower bytes returned
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= mdr_pkg::RST_BYTE;
    end
    else
    begin
      rd_valid_q <= i_rd_en;
      if (i_rd_en)
      begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  assign o_rd_valid = rd_valid_q;
  assign o_rd_data  = rd_data_q;

  // ****************************************
  // Tach output control
  // ****************************************
  // First startup ends when the drive leaves open loop for the first
  // time after reset; later restarts count as subsequent.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      open_loop_q  <= 1'b0;
      first_done_q <= 1'b0;
    end
    else
    begin
      open_loop_q <= i_open_loop;
      if (open_loop_q && !i_open_loop)
      begin
        first_done_q <= 1'b1;
      end
    end
  end

  // Unused select code 3 is treated as hold high.
  // open-loop option decode
  always_comb
  begin
    tach_d = tach_q;
    if (i_rotor_locked)
      tach_d = 1'b1;
    else if (!i_open_loop)
      tach_d = i_tach_toggle ? !tach_q : tach_q;
    else if (i_open_loop_tach_select == mdr_pkg::OL_FOLLOW)
      tach_d = i_tach_toggle ? !tach_q : tach_q;
    else if ((i_open_loop_tach_select == mdr_pkg::OL_FIRST) && !first_done_q)
      tach_d = i_tach_toggle ? !tach_q : tach_q;
    else
      tach_d = 1'b1;
  end

  // Idle level of the tach pin is high.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      tach_q <= 1'b1;
    else
      tach_q <= tach_d;
  end

  assign o_tach_out = tach_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_lock_tach_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rotor_locked |=> o_tach_out)
    else $error("tach not high while locked");

  a_ol_hold_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_open_loop && (i_open_loop_tach_select == mdr_pkg::OL_HIGH)) |=> o_tach_out)
    else $error("tach not held high in open loop");

  a_ol_follow_tog: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_open_loop && !i_rotor_locked && i_tach_toggle &&
     (i_open_loop_tach_select == mdr_pkg::OL_FOLLOW))
    |=> (o_tach_out != $past(o_tach_out)))
    else $error("tach did not toggle at drive rate");

  a_first_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (first_done_q && i_open_loop &&
     (i_open_loop_tach_select == mdr_pkg::OL_FIRST)) |=> o_tach_out)
    else $error("tach pulsed on a later restart");

  a_snap_take: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd_en && (i_rd_addr == mdr_pkg::ADDR_SPEED_HI))
    |=> (speed_snap_q == $past(speed_q[7:0])))
    else $error("lower byte not captured on upper read");

  a_snap_return: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd_en && (i_rd_addr == mdr_pkg::ADDR_PER_LO))
    |=> (o_rd_valid && (o_rd_data == $past(period_snap_q))))
    else $error("lower byte read not from snapshot");

  a_status_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd_en && (i_rd_addr == mdr_pkg::ADDR_STATUS))
    |=> (o_rd_data[mdr_pkg::ST_OVER_TEMP] == $past(i_over_temp, 2)))
    else $error("status flag read wrong");

  a_pos_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ipd_done && (i_ipd_sector == 3'h5) && (i_ipd_advance == 2'h3))
    |=> (pos_q == 8'h2A))
    else $error("position code not summed mod 256");

  a_stop_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_spinning && !start_q) |=> $stable(period_q))
    else $error("period changed while stopped");

  a_speed_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    start_q |-> ##21 div_bus.done ##1 (speed_q == $past(div_bus.quot)))
    else $error("speed not updated after period");

endmodule
`default_nettype wire

/* hw/mdr_pkg.sv */
// Constants and helpers shared by the diagnostic readback block.
package mdr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h11;
  localparam logic [7:0] ADDR_SPEED_LO = 8'h12;
  localparam logic [7:0] ADDR_PER_HI   = 8'h13;
  localparam logic [7:0] ADDR_PER_LO   = 8'h14;
  localparam logic [7:0] ADDR_KT_HI    = 8'h15;
  localparam logic [7:0] ADDR_KT_LO    = 8'h16;
  localparam logic [7:0] ADDR_POS      = 8'h19;
  localparam logic [7:0] ADDR_SUPPLY   = 8'h1A;
  localparam logic [7:0] ADDR_CMD      = 8'h1B;
  localparam logic [7:0] ADDR_DUTY     = 8'h1C;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         ST_OVER_TEMP  = 7;
  localparam int         ST_SLEEP      = 6;
  localparam int         ST_OVER_CURR  = 5;
  localparam int         ST_LOCKED     = 4;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          TICK_US     = 10;
  localparam int          TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [7:0]  TICK_LAST   = 8'(TICK_CYCLES - 1);
  // Speed is ten times frequency, so speed = 10 / (ticks * tick time).
  localparam logic [19:0] SPEED_NUM   = 20'(10_000_000 / TICK_US);
  localparam logic [4:0]  DIV_LAST    = 5'h13;

  // ****************************************
  // Open-loop tach options and command sources
  // ****************************************
  localparam logic [1:0] OL_FOLLOW  = 2'h0;
  localparam logic [1:0] OL_HIGH    = 2'h1;
  localparam logic [1:0] OL_FIRST   = 2'h2;
  localparam logic [1:0] SRC_PWM    = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;

  // Sector and advance codes of the sensed position.
  function automatic logic [7:0] mdr_pos_code(input logic [2:0] sec,
                                              input logic [1:0] adv);
    logic [7:0] s;
    logic [7:0] a;
    case (sec)
      3'h1:    s = 8'h2B;
      3'h2:    s = 8'h55;
      3'h3:    s = 8'h80;
      3'h4:    s = 8'hAB;
      3'h5:    s = 8'hD5;
      default: s = 8'h00;
    endcase
    case (adv)
      2'h0:    a = 8'h16;
      2'h1:    a = 8'h2C;
      2'h2:    a = 8'h3F;
      default: a = 8'h55;
    endcase
    // Eight-bit sum wraps, which is the modulo 256 of the code.
    return s + a;
  endfunction

endpackage

/* hw/mdr_div_if.sv */
// Request and answer bundle between the readback block and its divider.
`timescale 1ns/1ps
`default_nettype none
interface mdr_div_if;
  logic        start;
  logic [15:0] divisor;
  logic        done;
  logic [15:0] quot;
  modport master (output start, output divisor, input done, input quot);
  modport worker (input start, input divisor, output done, output quot);
endinterface
`default_nettype wire

/* hw/mdr_divider.sv */
// Sequential divider turning the period count into a speed value.
`timescale 1ns/1ps
`default_nettype none
module mdr_divider
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Request and answer
  mdr_div_if.worker div
);

  typedef enum logic [0:0] {DV_IDLE, DV_RUN} mdr_dstate_e;

  mdr_dstate_e state_q;
  logic [15:0] rem_q;
  logic [19:0] dvd_q;
  logic [19:0] quo_q;
  logic [15:0] den_q;
  logic [4:0]  cnt_q;
  logic        done_q;
  logic [15:0] res_q;
  logic [16:0] trial;
  logic        fits;
  logic [19:0] quo_d;

  // One restoring step: shift in the next dividend bit and try.
  always_comb
  begin
    trial = {rem_q, dvd_q[19]};
    fits  = trial >= {1'b0, den_q};
    quo_d = {quo_q[18:0], fits};
  end

  // ****************************************
  // Division sequence
  // ****************************************
  // Twenty steps per result; a saturated quotient reads as all ones.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= DV_IDLE;
      rem_q   <= 16'h0000;
      dvd_q   <= 20'h00000;
      quo_q   <= 20'h00000;
      den_q   <= 16'h0000;
      cnt_q   <= 5'h00;
      done_q  <= 1'b0;
      res_q   <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        DV_IDLE:
        begin
          if (div.start)
          begin
            rem_q   <= 16'h0000;
            dvd_q   <= mdr_pkg::SPEED_NUM;
            quo_q   <= 20'h00000;
            den_q   <= div.divisor;
            cnt_q   <= 5'h00;
            state_q <= DV_RUN;
          end
        end
        default:
        begin
          rem_q <= fits ? 16'(trial - {1'b0, den_q}) : trial[15:0];
          dvd_q <= {dvd_q[18:0], 1'b0};
          quo_q <= quo_d;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == mdr_pkg::DIV_LAST)
          begin
            res_q   <= (quo_d[19:16] != 4'h0) ? 16'hFFFF : quo_d[15:0];
            done_q  <= 1'b1;
            state_q <= DV_IDLE;
          end
        end
      endcase
    end
  end

  assign div.done = done_q;
  assign div.quot = res_q;

endmodule
`default_nettype wire

/* testbench/mdr_host.sv */
// Host side model that issues byte reads toward the readback block.
`timescale 1ns/1ps
`default_nettype none
module mdr_host
(
  // Clock
  input  wire logic       i_clk,
  // Read port toward the device
  output logic            o_rd_en,
  output logic [7:0]      o_rd_addr
);
  // The address is scrambled when idle so a stale value never passes as a valid one.
  initial
  begin
    o_rd_en   = 1'b0;
    o_rd_addr = 8'hA5;
  end

  // One byte read, strobe held for exactly one edge.
  task automatic read1(input logic [7:0] a);
    @(posedge i_clk);
    o_rd_en   <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_clk);
    o_rd_en   <= 1'b0;
    o_rd_addr <= ~a;
  endtask

  // upper byte first
  // Gap zero reads the pair back to back, otherwise idles between the two bytes.
  task automatic read_pair(input logic [7:0] hi, input int gap);
    if (gap == 0)
    begin
      @(posedge i_clk);
      o_rd_en   <= 1'b1;
      o_rd_addr <= hi;
      @(posedge i_clk);
      o_rd_addr <= hi + 8'h01;
      @(posedge i_clk);
      o_rd_en   <= 1'b0;
      o_rd_addr <= ~hi;
    end
    else
    begin
      read1(hi);
      repeat (gap) @(posedge i_clk);
      read1(hi + 8'h01);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/mdr_readback_test.sv */
// Self-checking bench of the diagnostic readback and tach control block.
`timescale 1ns/1ps
`default_nettype none
module mdr_readback_test;
  logic        clk;
  logic        nrst;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        ot, slp, oc, lk, spin, ol, zc, ktv, ipdv, supv, tog, tach;
  logic [15:0] kt;
  logic [2:0]  sec;
  logic [1:0]  adv, src, tsel;
  logic [7:0]  sup, pwm, ana, duty, e;
  logic [8:0]  ser;
  logic [15:0] v, w;
  logic [4:0]  tt;
  logic        tm;
  logic [7:0]  exp_q[$];
  int          seed, failures, n_compared;
  localparam logic [7:0] SEC_C [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
  localparam logic [7:0] ADV_C [4] = '{8'h16, 8'h2C, 8'h3F, 8'h55};
  // Tach steps {open_loop, select, locked, expect_toggle}; a non-toggling step must read high.
  // Step 3 leaves open loop, so step 4 is a later restart with the first-startup option.
  localparam logic [4:0] TACH_T [10] = '{5'h11, 5'h19, 5'h14, 5'h02, 5'h18,
                                         5'h01, 5'h02, 5'h14, 5'h01, 5'h1C};

  mdr_host i_mdr_host (.i_clk(clk), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

  mdr_readback i_mdr_readback (
    .i_clk(clk), .i_nrst(nrst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_over_temp(ot),
    .i_sleep_state(slp), .i_over_curr(oc), .i_rotor_locked(lk), .i_spinning(spin),
    .i_open_loop(ol), .i_zc_u(zc), .i_kt_valid(ktv), .i_kt_value(kt),
    .i_ipd_done(ipdv), .i_ipd_sector(sec), .i_ipd_advance(adv),
    .i_supply_valid(supv), .i_supply_code(sup), .i_cmd_source(src),
    .i_pwm_duty(pwm), .i_analog_level(ana), .i_serial_speed(ser), .i_out_duty(duty),
    .i_open_loop_tach_select(tsel), .i_tach_toggle(tog), .o_tach_out(tach));

  // The clock runs at 20 MHz.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Notes the expected byte, then lets the host read it.
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_mdr_host.read1(a);
  endtask

  task automatic end_sim;
    $display("Counts: %0d compared, %0d failed", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Answers are checked at the falling edge, once the registered outputs have settled.
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        failures++;
        $display("[ERR] %0t read answer with nothing expected", $time);
      end
      else
        check({8'h00, rd_data}, {8'h00, exp_q.pop_front()}, "read data");
    end
  end

  // The whole run needs about 10400 cycles, so 40000 cycles means a hang.
  initial
  begin
    #(50 * 40000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    seed = 7;
    {nrst, ot, slp, oc, lk, spin, ol, zc, ktv, ipdv, supv, tog} = '0;
    {kt, sec, adv, src, tsel, sup, pwm, ana, duty, ser} = '0;
    step(6);
    nrst <= 1'b1;
    for (int a = 8'h0E; a <= 8'h1E; a++)
      rd(8'(a), 8'h00);
    $display("reset test done");
    repeat (4)
    begin
      v = 16'($random(seed));
      @(posedge clk);
      {ot, slp, oc, lk} <= v[3:0];
      step(3);
      rd(8'h10, {v[3:0], 4'h0});
    end
    lk <= 1'b0;
    $display("status test done");
    for (int s = 0; s < 6; s++)
      for (int d = 0; d < 4; d++)
      begin
        @(posedge clk);
        ipdv <= 1'b1;
        sec  <= 3'(s);
        adv  <= 2'(d);
        @(posedge clk);
        ipdv <= 1'b0;
        rd(8'h19, SEC_C[s] + ADV_C[d]);
      end
    $display("position test done");
    v = 16'($random(seed));
    @(posedge clk);
    supv <= 1'b1;
    sup  <= v[7:0];
    duty <= v[15:8];
    @(posedge clk);
    supv <= 1'b0;
    rd(8'h1A, v[7:0]);
    rd(8'h1C, v[15:8]);
    for (int c = 0; c < 4; c++)
    begin
      v = 16'($random(seed));
      @(posedge clk);
      src <= 2'(c);
      pwm <= v[7:0];
      ana <= v[15:8];
      ser <= v[8:0] ^ 9'h155;
      step(3);
      e = (c == 0) ? v[7:0] : (c == 1) ? v[15:8] : 8'((v[8:0] ^ 9'h155) >> 1);
      rd(8'h1B, e);
    end
    $display("command test done");
    v = 16'($random(seed));
    w = 16'($random(seed));
    @(posedge clk);
    spin <= 1'b1;
    ktv  <= 1'b1;
    kt   <= v;
    @(posedge clk);
    ktv  <= 1'b0;
    rd(8'h15, v[15:8]);
    @(posedge clk);
    ktv  <= 1'b1;
    kt   <= w;
    @(posedge clk);
    ktv  <= 1'b0;
    rd(8'h16, v[7:0]);
    exp_q.push_back(w[15:8]);
    exp_q.push_back(w[7:0]);
    i_mdr_host.read_pair(8'h15, 0);
    $display("snapshot test done");
    for (int z = 0; z < 2; z++)
    begin
      @(posedge clk);
      zc <= 1'b1;
      @(posedge clk);
      zc <= 1'b0;
      if (z == 0)
        step(200 * 50 + 100);
    end
    step(30);
    spin <= 1'b0;
    step(5);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h32);
    i_mdr_host.read_pair(8'h13, 3);
    exp_q.push_back(8'h4E);
    exp_q.push_back(8'h20);
    i_mdr_host.read_pair(8'h11, 0);
    $display("speed test done");
    tm = 1'b1;
    for (int t = 0; t < 10; t++)
    begin
      tt = TACH_T[t];
      @(posedge clk);
      ol   <= tt[4];
      tsel <= tt[3:2];
      lk   <= tt[1];
      tog  <= 1'b1;
      @(posedge clk);
      tog  <= 1'b0;
      tm = tt[0] ? ~tm : 1'b1;
      #1;
      check({15'h0, tach}, {15'h0, tm}, "tach level");
    end
    $display("tach test done");
    step(5);
    check(16'(exp_q.size()), 16'h0000, "answers missing");
    end_sim();
  end
endmodule
`default_nettype wire
